//--- logic/tmr3_ctrl.sv
`include "tmr_cfg.svh"

module tmr3_ctrl #(
  parameter int SYS_DIV = `TMR_SYS_DIV,
  parameter int SRC_DIV = `TMR_SRC_DIV
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire tmr_pkg::tmr_byte_t sfr_addr_i,
  input wire tmr_pkg::tmr_byte_t sfr_page_i,
  input wire logic sfr_wr_i,
  input wire tmr_pkg::tmr_byte_t sfr_wdata_i,
  output tmr_pkg::tmr_byte_t sfr_rdata_o,
  input wire logic high_byte_clock_select_i,
  input wire logic low_byte_clock_select_i,
  input wire logic timer_irq_enable_i,
  input wire logic ext_osc_i,
  input wire logic low_freq_osc_i,
  output logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;

  localparam int PW = (SYS_DIV > 1) ? $clog2(SYS_DIV) : 1;

  tmr_byte_t timer3_control;
  tmr_byte_t reload_low_byte;
  tmr_byte_t reload_high_byte;
  tmr_byte_t count_low_byte;
  tmr_byte_t count_high_byte;
  tmr_byte_t next_control;
  tmr_byte_t next_reload_low;
  tmr_byte_t next_reload_high;
  tmr_byte_t next_rdata;
  logic [PW-1:0] presc;
  logic [PW-1:0] next_presc;

  logic page_hit;
  logic wr_ctrl;
  logic wr_rll;
  logic wr_rlh;
  logic wr_cnt_l;
  logic wr_cnt_h;
  logic high_byte_overflow_flag;
  logic low_byte_overflow_flag;
  logic low_byte_interrupt_enable;
  logic osc_capture_enable;
  logic split_mode_select;
  logic run_control;
  tmr_xclk_t alt_clock_select;

  logic div12_tick;
  logic ext_tick;
  logic lfo_tick;
  logic lfo_fall;
  logic alt_tick;
  logic tick_l;
  logic tick_h;
  logic inc_l;
  logic inc_h;
  logic wrap_load_l;
  logic ovf_l;
  logic ovf_h;
  logic capture;

  assign page_hit = (sfr_page_i == `TMR_SFR_PAGE);
  assign wr_ctrl = sfr_wr_i & page_hit & (sfr_addr_i == `TMR_ADDR_CTRL);
  assign wr_rll = sfr_wr_i & page_hit & (sfr_addr_i == `TMR_ADDR_RELOAD_LO);
  assign wr_rlh = sfr_wr_i & page_hit & (sfr_addr_i == `TMR_ADDR_RELOAD_HI);
  assign wr_cnt_l = sfr_wr_i & page_hit & (sfr_addr_i == `TMR_ADDR_COUNT_LO);
  assign wr_cnt_h = sfr_wr_i & page_hit & (sfr_addr_i == `TMR_ADDR_COUNT_HI);

  assign high_byte_overflow_flag = timer3_control[`TMR_BIT_HIGH_FLAG];
  assign low_byte_overflow_flag = timer3_control[`TMR_BIT_LOW_FLAG];
  assign low_byte_interrupt_enable = timer3_control[`TMR_BIT_LOW_IRQ_EN];
  assign osc_capture_enable = timer3_control[`TMR_BIT_CAPTURE_EN];
  assign split_mode_select = timer3_control[`TMR_BIT_SPLIT];
  assign run_control = timer3_control[`TMR_BIT_RUN];
  assign alt_clock_select = timer3_control[`TMR_BIT_XCLK_HI:`TMR_BIT_XCLK_LO];

  // System clock divided by twelve
  assign div12_tick = (presc == PW'(SYS_DIV - 1));

  always_comb begin
    next_presc = div12_tick ? '0 : PW'(presc + 1'b1);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc <= '0;
    end else begin
      presc <= next_presc;
    end
  end

  // Both oscillator pins are asynchronous; each passes two flops before any logic
  tmr_src_sync #(.SRC_DIV(SRC_DIV)) u_ext_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .src_i(ext_osc_i),
    .tick_o(ext_tick),
    .fall_o()
  );

  tmr_src_sync #(.SRC_DIV(SRC_DIV)) u_lfo_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .src_i(low_freq_osc_i),
    .tick_o(lfo_tick),
    .fall_o(lfo_fall)
  );

  // One alternate source serves both bytes; the reserved code yields no ticks
  always_comb begin
    case (alt_clock_select)
      `TMR_XCLK_DIV12: alt_tick = div12_tick;
      `TMR_XCLK_EXT: alt_tick = ext_tick;
      `TMR_XCLK_LFO: alt_tick = lfo_tick;
      default: alt_tick = 1'b0;
    endcase
  end

  assign tick_l = low_byte_clock_select_i ? 1'b1 : alt_tick;
  assign tick_h = high_byte_clock_select_i ? 1'b1 : alt_tick;

  // Mode steering: 16-bit chains high off the low carry, split runs two 8-bit timers
  always_comb begin
    if (split_mode_select) begin
      inc_l = tick_l;
      wrap_load_l = 1'b1;
    end else begin
      inc_l = run_control & tick_l;
      wrap_load_l = (count_high_byte == `TMR_BYTE_MAX);
    end
  end

  // Kept apart from the block above so the low carry does not loop through one process
  assign inc_h = split_mode_select ? (run_control & tick_h) : ovf_l;

  tmr_byte_cnt u_cnt_lo (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .inc_i(inc_l),
    .wrap_load_i(wrap_load_l),
    .reload_i(reload_low_byte),
    .wr_i(wr_cnt_l),
    .wdata_i(sfr_wdata_i),
    .count_o(count_low_byte),
    .ovf_o(ovf_l)
  );

  tmr_byte_cnt u_cnt_hi (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .inc_i(inc_h),
    .wrap_load_i(1'b1),
    .reload_i(reload_high_byte),
    .wr_i(wr_cnt_h),
    .wdata_i(sfr_wdata_i),
    .count_o(count_high_byte),
    .ovf_o(ovf_h)
  );

  assign capture = osc_capture_enable & lfo_fall;

  // Hardware sets win over a software clear in the same cycle
  always_comb begin
    next_control = timer3_control;
    if (wr_ctrl) begin
      next_control = sfr_wdata_i;
    end
    if (ovf_h | capture) begin
      next_control[`TMR_BIT_HIGH_FLAG] = 1'b1;
    end
    if (ovf_l) begin
      next_control[`TMR_BIT_LOW_FLAG] = 1'b1;
    end
  end

  // A capture overrides a simultaneous software write of the reload pair
  always_comb begin
    next_reload_low = wr_rll ? sfr_wdata_i : reload_low_byte;
    next_reload_high = wr_rlh ? sfr_wdata_i : reload_high_byte;
    if (capture) begin
      next_reload_low = count_low_byte;
      next_reload_high = count_high_byte;
    end
  end

  always_comb begin
    next_rdata = `TMR_READ_UNMAPPED;
    if (page_hit) begin
      case (sfr_addr_i)
        `TMR_ADDR_CTRL: next_rdata = timer3_control;
        `TMR_ADDR_RELOAD_LO: next_rdata = reload_low_byte;
        `TMR_ADDR_RELOAD_HI: next_rdata = reload_high_byte;
        `TMR_ADDR_COUNT_LO: next_rdata = count_low_byte;
        `TMR_ADDR_COUNT_HI: next_rdata = count_high_byte;
        default: next_rdata = `TMR_READ_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer3_control <= `TMR_CTRL_RESET;
      reload_low_byte <= `TMR_BYTE_RESET;
      reload_high_byte <= `TMR_BYTE_RESET;
      sfr_rdata_o <= `TMR_READ_UNMAPPED;
    end else begin
      timer3_control <= next_control;
      reload_low_byte <= next_reload_low;
      reload_high_byte <= next_reload_high;
      sfr_rdata_o <= next_rdata;
    end
  end

  // Level request; the core sees it as long as a flag stays set and enabled
  assign irq_o = timer_irq_enable_i &
    (high_byte_overflow_flag |
     (low_byte_overflow_flag & low_byte_interrupt_enable));

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_high_flag_set: assert property (
    ovf_h |=> high_byte_overflow_flag)
    else $error("high flag not set after high byte rollover");

  a_wrap_16bit: assert property (
    (!split_mode_select && ovf_h) |->
      (count_high_byte == 8'hff) && (count_low_byte == 8'hff))
    else $error("16-bit high overflow without full wrap");

  a_high_irq: assert property (
    (ovf_h && timer_irq_enable_i) |=> (irq_o || !timer_irq_enable_i))
    else $error("no interrupt after high overflow");

  a_flag_sticky: assert property (
    (high_byte_overflow_flag && !wr_ctrl) |=> high_byte_overflow_flag)
    else $error("high flag cleared without a write");

  a_low_flag_set: assert property (
    ovf_l |=> low_byte_overflow_flag)
    else $error("low flag not set after low byte rollover");

  a_low_irq: assert property (
    (low_byte_overflow_flag && low_byte_interrupt_enable && timer_irq_enable_i) |-> irq_o)
    else $error("low overflow interrupt missing");

  a_capture_copy: assert property (
    capture |=> (reload_low_byte == $past(count_low_byte)) &&
      (reload_high_byte == $past(count_high_byte)) && high_byte_overflow_flag)
    else $error("capture did not copy count or set flag");

  a_run_gate: assert property (
    (!run_control && !split_mode_select) |-> !inc_l && !inc_h)
    else $error("16-bit timer counted while stopped");

  a_split_low_free: assert property (
    (split_mode_select && !run_control && low_byte_clock_select_i && !wr_cnt_l &&
      count_low_byte != 8'hff) |=> count_low_byte == $past(count_low_byte) + 8'h01)
    else $error("split low byte did not count while run is off");

  a_div12_spacing: assert property (
    div12_tick |=> !div12_tick [*8])
    else $error("divide-by-twelve ticks too close");

  a_reload_16bit: assert property (
    (!split_mode_select && ovf_h && !wr_cnt_l && !wr_cnt_h) |=>
      {count_high_byte, count_low_byte} == $past({reload_high_byte, reload_low_byte}))
    else $error("16-bit wrap did not load the reload pair");

  a_ctrl_write: assert property (
    (wr_ctrl && !ovf_h && !ovf_l && !capture) |=> timer3_control == $past(sfr_wdata_i))
    else $error("control write did not land");

  a_irq_gate: assert property (
    !timer_irq_enable_i |-> !irq_o)
    else $error("interrupt raised while disabled");

  c_full_wrap: cover property (!split_mode_select && ovf_h);
  c_split_high: cover property (split_mode_select && ovf_h);
  c_capture: cover property (capture);
  c_flag_race: cover property (wr_ctrl && ovf_l);
endmodule

//--- logic/tmr_cfg.svh
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH

// Register addresses on the special function register bus
`define TMR_ADDR_CTRL 8'h91
`define TMR_ADDR_RELOAD_LO 8'h92
`define TMR_ADDR_RELOAD_HI 8'h93
`define TMR_ADDR_COUNT_LO 8'h94
`define TMR_ADDR_COUNT_HI 8'h95
`define TMR_SFR_PAGE 8'h00

// Control register field positions
`define TMR_BIT_HIGH_FLAG 7
`define TMR_BIT_LOW_FLAG 6
`define TMR_BIT_LOW_IRQ_EN 5
`define TMR_BIT_CAPTURE_EN 4
`define TMR_BIT_SPLIT 3
`define TMR_BIT_RUN 2
`define TMR_BIT_XCLK_HI 1
`define TMR_BIT_XCLK_LO 0

// Reset values and the byte maximum
`define TMR_CTRL_RESET 8'h00
`define TMR_BYTE_RESET 8'h00
`define TMR_BYTE_MAX 8'hff
`define TMR_READ_UNMAPPED 8'h00

// Alternate clock codes
`define TMR_XCLK_DIV12 2'h0
`define TMR_XCLK_EXT 2'h1
`define TMR_XCLK_RSVD 2'h2
`define TMR_XCLK_LFO 2'h3

// Divider ratios, in input cycles per timer tick
`define TMR_SYS_DIV 12
`define TMR_SRC_DIV 8

`endif

//--- logic/tmr_pkg.sv
package tmr_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] tmr_byte_t;
  typedef logic [1:0] tmr_xclk_t;
endpackage

//--- logic/tmr_src_sync.sv
`include "tmr_cfg.svh"

module tmr_src_sync #(
  parameter int SRC_DIV = `TMR_SRC_DIV
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic src_i,
  output logic tick_o,
  output logic fall_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;

  localparam int CW = (SRC_DIV > 1) ? $clog2(SRC_DIV) : 1;

  logic sync_a;
  logic sync_b;
  logic prev;
  logic [CW-1:0] div_cnt;
  logic next_sync_a;
  logic next_sync_b;
  logic next_prev;
  logic [CW-1:0] next_div_cnt;
  logic rise;

  // Edge detection looks only at the second stage, never the first
  assign rise = sync_b & ~prev;
  assign fall_o = prev & ~sync_b;
  assign tick_o = rise & (div_cnt == CW'(SRC_DIV - 1));

  always_comb begin
    next_sync_a = src_i;
    next_sync_b = sync_a;
    next_prev = sync_b;
    next_div_cnt = div_cnt;
    if (rise) begin
      next_div_cnt = (div_cnt == CW'(SRC_DIV - 1)) ? '0 : CW'(div_cnt + 1'b1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      div_cnt <= '0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      prev <= next_prev;
      div_cnt <= next_div_cnt;
    end
  end
endmodule

//--- logic/tmr_byte_cnt.sv
`include "tmr_cfg.svh"

module tmr_byte_cnt (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic inc_i,
  input wire logic wrap_load_i,
  input wire tmr_pkg::tmr_byte_t reload_i,
  input wire logic wr_i,
  input wire tmr_pkg::tmr_byte_t wdata_i,
  output tmr_pkg::tmr_byte_t count_o,
  output logic ovf_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;

  tmr_byte_t next_count;

  assign ovf_o = inc_i & (count_o == `TMR_BYTE_MAX);

  // A software write in the same cycle as a tick wins, so the value written is exact
  always_comb begin
    next_count = count_o;
    if (wr_i) begin
      next_count = wdata_i;
    end else if (ovf_o) begin
      next_count = wrap_load_i ? reload_i : `TMR_BYTE_RESET;
    end else if (inc_i) begin
      next_count = count_o + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= `TMR_BYTE_RESET;
    end else begin
      count_o <= next_count;
    end
  end
endmodule

//--- bench/tmr_osc_model.sv
module tmr_osc_model (
  output logic ext_osc_o,
  output logic lfo_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both oscillators run free and share no phase with the core clock
  initial begin
    ext_osc_o = 1'b0;
    lfo_o = 1'b0;
  end
  always #7.3 ext_osc_o = ~ext_osc_o;
  // Slow against the core clock so capture sees a clean falling edge
  always #20.7 lfo_o = ~lfo_o;
endmodule

//--- bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmr_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  tmr_byte_t sfr_addr_i = 8'h00;
  tmr_byte_t sfr_page_i = 8'h00;
  tmr_byte_t sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic hi_sel = 1'b0;
  logic lo_sel = 1'b1;
  logic irq_en = 1'b1;
  tmr_byte_t sfr_rdata_o;
  logic irq_o;
  logic ext_osc;
  logic low_freq_oscillator;
  int fail_count = 0;
  int checks = 0;
  tmr_byte_t r;
  tmr_byte_t lo_t [4] = '{8'h2f, 8'h13, 8'h00, 8'h06};
  tmr_byte_t hi_t [4] = '{8'h34, 8'h16, 8'h00, 8'h08};

  always #2 core_clk_i = ~core_clk_i;

  tmr_osc_model osc_u (.ext_osc_o(ext_osc), .lfo_o(low_freq_oscillator));

  tmr3_ctrl dut_u (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_page_i(sfr_page_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .high_byte_clock_select_i(hi_sel),
    .low_byte_clock_select_i(lo_sel), .timer_irq_enable_i(irq_en),
    .ext_osc_i(ext_osc), .low_freq_osc_i(low_freq_oscillator), .irq_o(irq_o)
  );

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Strobe stands across one rising edge; the idle cycle after it keeps writes apart
  task automatic wr(input tmr_byte_t a, input tmr_byte_t d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge core_clk_i);
    sfr_wr_i = 1'b0;
    @(negedge core_clk_i);
  endtask

  task automatic rd(input tmr_byte_t a, output tmr_byte_t d);
    sfr_addr_i = a;
    @(negedge core_clk_i);
    d = sfr_rdata_o;
  endtask

  // Range compare; an unknown makes the test non-one and so fails
  task automatic chk(input tmr_byte_t got, input tmr_byte_t lo, input tmr_byte_t hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic rd_chk(input tmr_byte_t a, input tmr_byte_t lo, input tmr_byte_t hi);
    tmr_byte_t d;
    rd(a, d);
    chk(d, lo, hi);
  endtask

  task automatic irq_is(input logic e);
    chk({7'h00, irq_o}, {7'h00, e}, {7'h00, e});
  endtask

  task automatic regs_zero();
    for (int a = 8'h91; a <= 8'h96; a++) begin
      rd_chk(a[7:0], 8'h00, 8'h00);
    end
    irq_is(1'b0);
  endtask

  task automatic results();
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100us;
    fail_count++;
    results();
  end

  initial begin
    idle(6);
    rst_i = 1'b0;
    regs_zero();
    sfr_page_i = 8'h0f;
    wr(8'h91, 8'h04);
    rd_chk(8'h91, 8'h00, 8'h00);
    sfr_page_i = 8'h00;
    rd_chk(8'h91, 8'h00, 8'h00);
    // 16-bit wrap from near the top
    wr(8'h92, 8'h34);
    wr(8'h93, 8'h12);
    wr(8'h94, 8'hf0);
    wr(8'h95, 8'hff);
    wr(8'h91, 8'h04);
    idle(30);
    rd_chk(8'h91, 8'hc4, 8'hc4);
    irq_is(1'b1);
    irq_en = 1'b0;
    idle(1);
    irq_is(1'b0);
    irq_en = 1'b1;
    rd_chk(8'h95, 8'h12, 8'h12);
    idle(40);
    rd_chk(8'h91, 8'hc4, 8'hc4);
    wr(8'h91, 8'h04);
    rd_chk(8'h91, 8'h04, 8'h04);
    irq_is(1'b0);
    wr(8'h91, 8'h00);
    rd(8'h94, r);
    idle(20);
    rd_chk(8'h94, r, r);
    // Alternate source codes, low byte on the alternate clock
    lo_sel = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h91, i[7:0]);
      wr(8'h94, 8'h00);
      wr(8'h95, 8'h00);
      wr(8'h91, 8'h04 | i[7:0]);
      idle(600);
      wr(8'h91, i[7:0]);
      rd_chk(8'h94, lo_t[i], hi_t[i]);
      rd_chk(8'h95, 8'h00, 8'h00);
    end
    // Capture on slow oscillator falls, counting every cycle
    lo_sel = 1'b1;
    wr(8'h91, 8'h00);
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h91, 8'h14);
    idle(100);
    rd_chk(8'h91, 8'h94, 8'h94);
    irq_is(1'b1);
    wr(8'h91, 8'h90);
    idle(30);
    rd(8'h94, r);
    chk(r, 8'h60, 8'h80);
    rd_chk(8'h92, r, r);
    rd_chk(8'h93, 8'h00, 8'h00);
    // Split mode, high byte stopped and then run undivided; second clear beats a capture racing the first
    wr(8'h91, 8'h00);
    wr(8'h91, 8'h00);
    wr(8'h92, 8'h80);
    wr(8'h93, 8'h77);
    wr(8'h94, 8'hf0);
    wr(8'h95, 8'h50);
    wr(8'h91, 8'h08);
    idle(40);
    rd_chk(8'h91, 8'h48, 8'h48);
    irq_is(1'b0);
    rd_chk(8'h95, 8'h50, 8'h50);
    rd_chk(8'h94, 8'h95, 8'ha0);
    wr(8'h91, 8'h28);
    irq_is(1'b0);
    idle(110);
    irq_is(1'b1);
    rd_chk(8'h91, 8'h68, 8'h68);
    hi_sel = 1'b1;
    wr(8'h95, 8'hf8);
    wr(8'h91, 8'h2c);
    idle(20);
    rd(8'h91, r);
    chk(r & 8'h80, 8'h80, 8'h80);
    rd_chk(8'h95, 8'h77, 8'h88);
    irq_is(1'b1);
    // Reset in mid-run with flags up
    rst_i = 1'b1;
    idle(2);
    rst_i = 1'b0;
    regs_zero();
    // Split: high byte undivided, low byte on the shared divide-by-12 source
    hi_sel = 1'b1;
    lo_sel = 1'b0;
    wr(8'h91, 8'h0c);
    idle(96);
    wr(8'h91, 8'h08);
    rd_chk(8'h95, 8'h5e, 8'h64);
    rd_chk(8'h94, 8'h06, 8'h0a);
    results();
  end
endmodule
